// >>> design/dsp_pkg.sv
// Shared constants and types for the dual serial board port decode.
package dsp_pkg;

    // Host I/O bus: address and data widths.
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 8;
    localparam int STRAP_W   = 5;
    localparam int SEL_W     = 3;

    // Low address field positions inside the selected block of eight.
    localparam int SEL_RATE_BIT = 2;     // One here selects the rate register.
    localparam int SEL_CHAN_BIT = 1;     // Zero is channel A, one channel B.
    localparam int SEL_CTRL_BIT = 0;     // Zero is data, one control/status.

    // Rate register layout and reset value.
    localparam int RATE_A_LSB = 4;
    localparam int RATE_B_LSB = 0;
    localparam int RATE_W     = 4;
    localparam logic [DATA_W-1:0] RATE_RST = 8'h00;

    // Interrupt sources: four per channel, eight vectors in all.
    localparam int NUM_SRC   = 8;
    localparam int CODE_W    = 3;
    localparam int VEC_LSB   = 1;        // Code sits in vector bits 3..1.

    // Rate clock table, in bit clock Hz, one entry per 4-bit code.
    localparam int unsigned RATE_HZ [16] = '{
        50, 75, 110, 150, 300, 600, 800, 1200,
        2400, 4800, 9600, 19200, 38400, 76800, 153600, 307200
    };
    localparam int unsigned CLK_HZ_DEF = 100_000_000;
    localparam int          DIV_W      = 24;

    // Host I/O bus request, as sampled on the system clock.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              iorq_n;
        logic              rd_n;
        logic              wr_n;
        logic              m1_n;
    } dsp_bus_t;

    // Interrupt sequencer states, Gray coded from idle through request to service.
    typedef enum logic [1:0] {
        DSP_IDLE = 2'b00,
        DSP_REQ  = 2'b01,
        DSP_SVC  = 2'b11
    } dsp_irq_st_t;

    // Pick the highest-priority pending source; index 0 ranks first.
    function automatic logic [CODE_W-1:0] dsp_first(
        input logic [NUM_SRC-1:0] pend
    );
        logic [CODE_W-1:0] code;
        code = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                code = CODE_W'(i);
            end
        end
        return code;
    endfunction

endpackage

// >>> design/dsp_rate_gen.sv
// One channel's programmable bit clock, as a one-cycle enable pulse.
`timescale 1ns/1ns
module dsp_rate_gen #(
    parameter int unsigned CLK_HZ = dsp_pkg::CLK_HZ_DEF
) (
    // Clock and synchronised reset.
    input  wire logic                      mclk_i,
    input  wire logic                      rst_n_i,
    // Rate code from the rate register.
    input  wire logic [dsp_pkg::RATE_W-1:0] code_i,
    // Bit clock enable.
    output logic                           tick_o
);

    typedef struct packed {
        logic [dsp_pkg::DIV_W-1:0]  cnt;
        logic [dsp_pkg::RATE_W-1:0] code;
        logic                       tick;
    } dsp_rg_st_t;

    dsp_rg_st_t                 st_ff;
    dsp_rg_st_t                 nxt_st;
    logic [dsp_pkg::DIV_W-1:0]  div_tab [16];

    // Divisors fold to constants, so no divider is built.
    for (genvar i = 0; i < 16; i++)
    begin : g_div
        assign div_tab[i] = dsp_pkg::DIV_W'(
            (CLK_HZ / dsp_pkg::RATE_HZ[i] > 1) ?
            CLK_HZ / dsp_pkg::RATE_HZ[i] : 1);
    end

    // Count up one bit period; a new code restarts the period so a
    // rate change never leaves a shortened first bit.
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        nxt_st.code = code_i;
        if (code_i != st_ff.code)
        begin
            nxt_st.cnt = '0;
        end
        else if (st_ff.cnt >= div_tab[code_i] - 1'b1)
        begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;

endmodule

// >>> design/dsp_port_decode.sv
// Host port decode, rate register and vectored interrupt daisy chain.
`timescale 1ns/1ns
// Contract
// - Respond to I/O cycles only when upper five bits match straps.
// - Low bits pick channel data or control ports.
// - Bit two high always selects rate register.
// - Upper nibble rates channel A, lower B.
// - Eight programmable vectors, daisy chained priority.
// - Rates span 50 to 307.2K baud.
module dsp_port_decode #(
    parameter int unsigned CLK_HZ = dsp_pkg::CLK_HZ_DEF
) (
    // Clock and reset.
    input  wire logic                          mclk_i,
    input  wire logic                          nrst_i,
    // Host I/O bus.
    input  wire dsp_pkg::dsp_bus_t             bus_i,
    input  wire logic [dsp_pkg::STRAP_W-1:0]   strap_i,
    output logic [dsp_pkg::DATA_W-1:0]         data_o,
    output logic                               data_oe_o,
    // Serial controller port selects and its read data.
    output logic                               cs_a_data_o,
    output logic                               cs_a_ctrl_o,
    output logic                               cs_b_data_o,
    output logic                               cs_b_ctrl_o,
    input  wire logic [dsp_pkg::DATA_W-1:0]    ch_rdata_i,
    // Bit clocks.
    output logic [dsp_pkg::RATE_W-1:0]         rate_sel_a_o,
    output logic [dsp_pkg::RATE_W-1:0]         rate_sel_b_o,
    output logic                               rate_tick_a_o,
    output logic                               rate_tick_b_o,
    // Interrupt events, vector base and daisy chain.
    input  wire logic [dsp_pkg::NUM_SRC-1:0]   event_i,
    input  wire logic [dsp_pkg::DATA_W-1:0]    vec_base_i,
    input  wire logic                          reti_i,
    input  wire logic                          iei_i,
    output logic                               ieo_o,
    output logic                               int_n_o,
    output logic                               int_n_oe_o
);

    typedef struct packed {
        logic [dsp_pkg::DATA_W-1:0]  rate;
        logic [dsp_pkg::DATA_W-1:0]  rdata;
        logic                        rd_oe;
        logic                        io_prev;
        logic [dsp_pkg::NUM_SRC-1:0] pend;
        logic [dsp_pkg::CODE_W-1:0]  code;
        dsp_pkg::dsp_irq_st_t        irq;
    } dsp_pd_st_t;

    dsp_pd_st_t                  st_ff;
    dsp_pd_st_t                  nxt_st;
    logic [1:0]                  rst_sync_ff;
    logic                        rst_n;
    logic                        io_cyc;
    logic                        hit;
    logic                        io_start;
    logic                        inta;
    logic                        inta_start;
    logic [dsp_pkg::SEL_W-1:0]   sel;

    // Reset takes hold asynchronously but is released on the clock.
    // Only the second flop is read, so nothing sees a half-made release.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_sync_ff <= 2'h0;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Bus cycle classification; M1 with IORQ is an acknowledge.
    assign sel        = bus_i.addr[dsp_pkg::SEL_W-1:0];
    assign io_cyc     = !bus_i.iorq_n && bus_i.m1_n &&
                        (!bus_i.rd_n || !bus_i.wr_n);
    assign inta       = !bus_i.iorq_n && !bus_i.m1_n;
    assign hit        = io_cyc &&
                        (bus_i.addr[dsp_pkg::ADDR_W-1:dsp_pkg::SEL_W]
                         == strap_i);
    assign io_start   = (io_cyc || inta) && !st_ff.io_prev;
    assign inta_start = inta && !st_ff.io_prev;

    // Port selects last for the whole cycle, as the controller expects.
    // Channel port decode.
    always_comb
    begin
        cs_a_data_o = 1'b0;
        cs_a_ctrl_o = 1'b0;
        cs_b_data_o = 1'b0;
        cs_b_ctrl_o = 1'b0;
        if (hit && !sel[dsp_pkg::SEL_RATE_BIT])
        begin
            unique case (sel[1:0])
                2'h0: cs_a_data_o = 1'b1;
                2'h1: cs_a_ctrl_o = 1'b1;
                2'h2: cs_b_data_o = 1'b1;
                2'h3: cs_b_ctrl_o = 1'b1;
            endcase
        end
    end

    // Next state: rate register, read data, interrupt sequencing.
    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.io_prev = io_cyc || inta;
        if (!(io_cyc || inta))
        begin
            nxt_st.rd_oe = 1'b0;
        end
        // Any address with bit two set.
        if (io_start && hit && sel[dsp_pkg::SEL_RATE_BIT] && !bus_i.wr_n)
        begin
            nxt_st.rate = bus_i.wdata;
        end
        // The rate register is write only, so of the reads only channel reads drive.
        if (io_start && hit && !sel[dsp_pkg::SEL_RATE_BIT] && !bus_i.rd_n)
        begin
            nxt_st.rdata = ch_rdata_i;
            nxt_st.rd_oe = 1'b1;
        end
        // Sticky requests, latched whether or not the chain allows.
        nxt_st.pend = st_ff.pend | event_i;
        unique case (st_ff.irq)
            dsp_pkg::DSP_IDLE:
            begin
                if (|st_ff.pend)
                begin
                    nxt_st.irq = dsp_pkg::DSP_REQ;
                end
            end
            dsp_pkg::DSP_REQ:
            begin
                // Only the first edge of an acknowledge acts, so a long
                // acknowledge cycle never hands out two sources.
                // Vector placed only when chain input is high.
                if (inta_start && iei_i)
                begin
                    nxt_st.code  = dsp_pkg::dsp_first(st_ff.pend);
                    nxt_st.pend  = (st_ff.pend &
                        ~(dsp_pkg::NUM_SRC'(1) <<
                          dsp_pkg::dsp_first(st_ff.pend))) | event_i;
                    nxt_st.rdata = vec_base_i;
                    nxt_st.rdata[dsp_pkg::VEC_LSB +: dsp_pkg::CODE_W] =
                        dsp_pkg::dsp_first(st_ff.pend);
                    nxt_st.rd_oe = 1'b1;
                    nxt_st.irq   = dsp_pkg::DSP_SVC;
                end
            end
            dsp_pkg::DSP_SVC:
            begin
                // Lower devices stay blocked until return from service.
                if (reti_i)
                begin
                    nxt_st.irq = dsp_pkg::DSP_IDLE;
                end
            end
            default:
            begin
                nxt_st.irq = dsp_pkg::DSP_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff      <= '0;
            st_ff.rate <= dsp_pkg::RATE_RST;
            st_ff.irq  <= dsp_pkg::DSP_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Bus data and daisy chain outputs.
    assign data_o     = st_ff.rdata;
    assign data_oe_o  = st_ff.rd_oe && (io_cyc || inta);
    // The interrupt line is open drain: the pin only ever pulls low, and
    // dropping the enable releases it to the pull-up.
    assign int_n_o    = 1'b0;
    // Request pulls the shared line low only while chain input is high.
    assign int_n_oe_o = (st_ff.irq == dsp_pkg::DSP_REQ) && iei_i;
    // Chain out drops as soon as a source is pending, so a lower device
    // never answers an acknowledge that belongs to this board.
    assign ieo_o      = iei_i && (st_ff.irq == dsp_pkg::DSP_IDLE) &&
                        !(|st_ff.pend);

    // Upper nibble channel A, lower nibble channel B.
    assign rate_sel_a_o = st_ff.rate[dsp_pkg::RATE_A_LSB +: dsp_pkg::RATE_W];
    assign rate_sel_b_o = st_ff.rate[dsp_pkg::RATE_B_LSB +: dsp_pkg::RATE_W];

    // One bit clock per channel, rates independent of each other.
    dsp_rate_gen #(
        .CLK_HZ (CLK_HZ)
    ) u_rate_a (
        .mclk_i (mclk_i),
        .rst_n_i(rst_n),
        .code_i (rate_sel_a_o),
        .tick_o (rate_tick_a_o)
    );

    dsp_rate_gen #(
        .CLK_HZ (CLK_HZ)
    ) u_rate_b (
        .mclk_i (mclk_i),
        .rst_n_i(rst_n),
        .code_i (rate_sel_b_o),
        .tick_o (rate_tick_b_o)
    );

endmodule

// >>> dv/dsp_decode_checker.sv
// Concurrent checks on the host port decode, bound to its top module.
`timescale 1ns/1ns
module dsp_decode_checker (
    // Clock and reset.
    input wire logic                        mclk_i,
    input wire logic                        nrst_i,
    // Host bus and port selects.
    input wire dsp_pkg::dsp_bus_t           bus_i,
    input wire logic [dsp_pkg::STRAP_W-1:0] strap_i,
    input wire logic                        data_oe_o,
    input wire logic                        cs_a_data_o,
    input wire logic                        cs_a_ctrl_o,
    input wire logic                        cs_b_data_o,
    input wire logic                        cs_b_ctrl_o,
    // Rate nibbles and interrupt chain.
    input wire logic [dsp_pkg::RATE_W-1:0]  rate_sel_a_o,
    input wire logic [dsp_pkg::RATE_W-1:0]  rate_sel_b_o,
    input wire logic [dsp_pkg::NUM_SRC-1:0] event_i,
    input wire logic                        iei_i,
    input wire logic                        ieo_o
);
    default clocking @(posedge mclk_i); endclocking
    logic [1:0] rst_q;
    logic       live;
    logic       io_ff;
    logic       hit;
    logic       first;
    logic       rate_wr;
    logic [3:0] cs;
    // The board leaves reset two edges after nrst_i, so the checks wait too.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign live = rst_q[1];
    default disable iff (!live);
    // Long cycles act once, so remember whether the last cycle was I/O.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            io_ff <= 1'b0;
        else
            io_ff <= !bus_i.iorq_n;
    end
    // Strap match on a plain read or write cycle.
    assign hit = !bus_i.iorq_n && bus_i.m1_n && !(bus_i.rd_n && bus_i.wr_n)
        && bus_i.addr[7:3] == strap_i;
    assign first = hit && !io_ff;
    assign rate_wr = first && !bus_i.wr_n && bus_i.addr[2];
    assign cs = {cs_a_data_o, cs_a_ctrl_o, cs_b_data_o, cs_b_ctrl_o};
    sequence rate_wr_s;
        rate_wr;
    endsequence
    sequence chan_rd_s;
        first && !bus_i.rd_n && !bus_i.addr[2];
    endsequence
    strap_gate_a: assert property (!hit |-> cs == 4'h0)
        else $error("port select without strap match");
    chan_sel_a: assert property (hit && !bus_i.addr[2]
        |-> cs == (4'h8 >> bus_i.addr[1:0])) else $error("wrong port select");
    rate_nosel_a: assert property (hit && bus_i.addr[2]
        |-> cs == 4'h0) else $error("rate access selected a port");
    rate_load_a: assert property (rate_wr_s |=>
        {rate_sel_a_o, rate_sel_b_o} == $past(bus_i.wdata))
        else $error("rate nibbles not loaded");
    rate_hold_a: assert property (!rate_wr
        |=> $stable({rate_sel_a_o, rate_sel_b_o}))
        else $error("rate changed");
    rate_wo_a: assert property (hit && !bus_i.rd_n
        && bus_i.addr[2] |=> !data_oe_o)
        else $error("rate register drove the bus");
    chan_rd_a: assert property (chan_rd_s |=> data_oe_o)
        else $error("channel read not driven");
    chain_block_a: assert property (!iei_i |-> !ieo_o)
        else $error("chain out high while chain in low");
    pend_block_a: assert property (event_i != 8'h00 |=> !ieo_o)
        else $error("pending source did not block chain");
endmodule
bind dsp_port_decode dsp_decode_checker chk (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus_i), .strap_i(strap_i),
    .data_oe_o(data_oe_o), .cs_a_data_o(cs_a_data_o),
    .cs_a_ctrl_o(cs_a_ctrl_o), .cs_b_data_o(cs_b_data_o),
    .cs_b_ctrl_o(cs_b_ctrl_o), .rate_sel_a_o(rate_sel_a_o),
    .rate_sel_b_o(rate_sel_b_o), .event_i(event_i), .iei_i(iei_i),
    .ieo_o(ieo_o));

// >>> dv/dsp_host.sv
// Host I/O bus model: write, read and interrupt acknowledge cycles.
`timescale 1ns/1ns
module dsp_host (
    // Clock.
    input wire logic                       mclk_i,
    // Bus towards the board.
    output dsp_pkg::dsp_bus_t              bus_o,
    input wire logic [dsp_pkg::DATA_W-1:0] data_i,
    input wire logic                       data_oe_i
);
    // Idle bus: strobes high, no cycle in progress.
    initial bus_o = '{8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1};
    // Kind 0 writes, 1 reads, 2 acknowledges; held for two edges.
    task automatic cycle(input logic [1:0] kind, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] q,
                         output logic oe);
        bus_o.addr   = a;
        bus_o.wdata  = d;
        bus_o.iorq_n = 1'b0;
        bus_o.wr_n   = kind != 2'h0;
        bus_o.rd_n   = kind != 2'h1;
        bus_o.m1_n   = kind != 2'h2;
        repeat (2) @(posedge mclk_i);
        q  = data_i;
        oe = data_oe_i;
        #1;
        // Released lines carry stale-looking garbage, not the last value.
        bus_o = '{~a, ~d, 1'b1, 1'b1, 1'b1, 1'b1};
        @(posedge mclk_i);
        #1;
    endtask
endmodule

// >>> dv/dsp_port_decode_bench.sv
// Self-checking bench for the host port decode.
`timescale 1ns/1ns
module dsp_port_decode_bench;
    typedef struct packed {
        logic [7:0] a;
        logic [3:0] cs;
        logic       oe;
    } dsp_row_t;
    localparam int unsigned CLK_HZ = 9_830_400;
    localparam dsp_row_t ROWS [9] = '{
        '{8'ha8, 4'h8, 1'h1}, '{8'ha9, 4'h4, 1'h1}, '{8'haa, 4'h2, 1'h1},
        '{8'hab, 4'h1, 1'h1}, '{8'hac, 4'h0, 1'h0}, '{8'had, 4'h0, 1'h0},
        '{8'hae, 4'h0, 1'h0}, '{8'haf, 4'h0, 1'h0}, '{8'h50, 4'h0, 1'h0}};
    logic              mclk, nrst, dout_oe, tick_a, tick_b, reti, iei, ieo;
    logic              int_n, int_oe, oe;
    logic [3:0]        cs, rsel_a, rsel_b;
    logic [7:0]        dout, rdata, evt, vbase, q;
    int                bad_count = 0;
    int                checks_done = 0;
    dsp_pkg::dsp_bus_t bus;
    dsp_host host (.mclk_i(mclk), .bus_o(bus), .data_i(dout),
        .data_oe_i(dout_oe));
    dsp_port_decode #(.CLK_HZ(CLK_HZ)) uut (.mclk_i(mclk), .nrst_i(nrst),
        .bus_i(bus), .strap_i(5'h15), .data_o(dout), .data_oe_o(dout_oe),
        .cs_a_data_o(cs[3]), .cs_a_ctrl_o(cs[2]), .cs_b_data_o(cs[1]),
        .cs_b_ctrl_o(cs[0]), .ch_rdata_i(rdata), .rate_sel_a_o(rsel_a),
        .rate_sel_b_o(rsel_b), .rate_tick_a_o(tick_a), .rate_tick_b_o(tick_b),
        .event_i(evt), .vec_base_i(vbase), .reti_i(reti), .iei_i(iei),
        .ieo_o(ieo), .int_n_o(int_n), .int_n_oe_o(int_oe));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Cycles from one bit clock pulse to the next, bounded.
    task automatic period(input logic b, input logic [31:0] exp);
        logic [31:0] n;
        n = 0;
        for (int i = 0; i < 2000 && !(b ? tick_b : tick_a); i++)
            @(posedge mclk) #1;
        do
        begin
            @(posedge mclk) #1;
            n++;
        end while (n < 2000 && !(b ? tick_b : tick_a));
        check(n, exp);
    endtask
    task automatic pulse(input logic [7:0] v);
        evt = v;
        @(posedge mclk) #1;
        evt = 8'h00;
        @(posedge mclk) #1;
    endtask
    // Acknowledge, optionally raise more events, then end service.
    task automatic ack_reti(input logic [7:0] exp, input logic [7:0] ev);
        host.cycle(2'h2, 8'h00, 8'h00, q, oe);
        check({oe, q, int_oe, ieo}, {1'b1, exp, 2'h0});
        if (ev != 8'h00)
            pulse(ev);
        reti = 1'b1;
        @(posedge mclk) #1;
        reti = 1'b0;
        @(posedge mclk) #1;
    endtask
    // Free-running clock at 100 MHz.
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Watchdog; the whole run needs under fifteen hundred cycles.
    initial
    begin
        #200000;
        bad_count++;
        finish_test();
    end
    initial
    begin
        nrst = 1'b0;
        evt = 8'h00;
        vbase = 8'ha1;
        reti = 1'b0;
        iei = 1'b1;
        rdata = 8'h00;
        repeat (4) @(posedge mclk);
        #1;
        check({dout_oe, cs, rsel_a, rsel_b}, 13'h0000);
        check({int_oe, ieo}, 2'h1);
        nrst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        // Decode table: one read cycle for each row.
        foreach (ROWS[i])
        begin
            rdata = ~ROWS[i].a;
            fork
                host.cycle(2'h1, ROWS[i].a, 8'h00, q, oe);
                #1 check(cs, ROWS[i].cs);
            join
            check(oe, ROWS[i].oe);
            if (ROWS[i].oe)
                check(q, rdata);
        end
        // Every alias of the rate register loads both nibbles.
        for (int k = 0; k < 4; k++)
        begin
            host.cycle(2'h0, 8'hac + 8'(k), 8'h13 * 8'(k + 1), q, oe);
            check({rsel_a, rsel_b}, 8'h13 * 8'(k + 1));
        end
        host.cycle(2'h0, 8'had, 8'hfe, q, oe);
        period(1'b0, 32'd32);
        period(1'b1, 32'd64);
        host.cycle(2'h0, 8'hae, 8'hbe, q, oe);
        period(1'b0, 32'd512);
        period(1'b1, 32'd64);
        // Blocked chain holds the request and ignores acknowledge.
        iei = 1'b0;
        pulse(8'h20);
        check({int_oe, ieo}, 2'h0);
        host.cycle(2'h2, 8'h00, 8'h00, q, oe);
        check(oe, 1'b0);
        iei = 1'b1;
        @(posedge mclk) #1;
        check({int_oe, ieo, int_n}, 3'h4);
        ack_reti(8'hab, 8'h44);
        ack_reti(8'ha5, 8'h00);
        ack_reti(8'had, 8'h00);
        check({int_oe, ieo}, 2'h1);
        // Reset in mid-run returns the rate register to its reset value.
        nrst = 1'b0;
        @(posedge mclk) #1;
        check({rsel_a, rsel_b, dout_oe, int_oe, ieo}, 11'h001);
        nrst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        host.cycle(2'h0, 8'haf, 8'h5a, q, oe);
        check({rsel_a, rsel_b}, 8'h5a);
        finish_test();
    end
endmodule
